/* File: rtl/bsj_defs.svh */
// Opcode values, field positions, selector codes and machine cycle lengths.
`ifndef BSJ_DEFS_SVH
`define BSJ_DEFS_SVH
`define BSJ_OP_CB     8'hcb
`define BSJ_OP_DD     8'hdd
`define BSJ_OP_FD     8'hfd
`define BSJ_OP_ABS    8'hc3
`define BSJ_F_GRP     7:6
`define BSJ_F_BIT     5:3
`define BSJ_F_REG     2:0
`define BSJ_F_SETBIT  6
`define BSJ_GRP_SET   2'h3
`define BSJ_GRP_CLR   2'h2
`define BSJ_R_MEM     3'h6
`define BSJ_R_H       3'h4
`define BSJ_R_L       3'h5
`define BSJ_LD_FIRST  4'h8
`define BSJ_LD_SECOND 4'h9
`define BSJ_LD_COUNT  4'ha
`define BSJ_RST_COUNT 16'h0000
// One clock state per clock cycle; lengths of each machine cycle.
`define BSJ_T_FETCH   3'h4
`define BSJ_T_DISP    3'h3
`define BSJ_T_IXOP    3'h5
`define BSJ_T_MRD     3'h4
`define BSJ_T_MWR     3'h3
`define BSJ_T_JBYTE   3'h3
// Whole-instruction totals in clock states.
`define BSJ_T_REGOP   5'h08
`define BSJ_T_HLOP    5'h0f
`define BSJ_T_INDEXED 5'h17
`define BSJ_T_ABS     5'h0a
`endif

/* File: rtl/bsj_pkg.sv */
// Types shared by the bit set, clear and jump executor.
package bsj_pkg;
    typedef enum logic [3:0] {
        bsj_st_idle, bsj_st_fetch, bsj_st_pfx2, bsj_st_cbop, bsj_st_disp,
        bsj_st_ixop, bsj_st_mrd, bsj_st_mwr, bsj_st_jlo, bsj_st_jhi
    } bsj_state_type;
    typedef enum logic [1:0] {
        bsj_ptr_main, bsj_ptr_first, bsj_ptr_second
    } bsj_ptr_type;
endpackage

/* File: rtl/bsj_alu_if.sv */
// Interface between the executor and its bit modify unit.
`timescale 1ns/1ns
interface bsj_alu_if;
    logic [7:0] operand;
    logic [2:0] bit_sel;
    logic       set_bit;
    logic [7:0] result;
    modport exec (output operand, output bit_sel, output set_bit, input result);
    modport alu  (input operand, input bit_sel, input set_bit, output result);
endinterface

/* File: rtl/bsj_bit_alu.sv */
// Bit modify unit that forces one selected bit of a byte to one or zero.
`timescale 1ns/1ns
module bsj_bit_alu (
    bsj_alu_if.alu alu
);
    // ------------------------------------------------------------------
    // Per-bit select
    // ------------------------------------------------------------------
    // Only the addressed bit takes the new value; bit 0 is the lowest bit.
    for (genvar i = 0; i < 8; i++) begin : g_bit
        assign alu.result[i] = (alu.bit_sel == 3'(i)) ? alu.set_bit : alu.operand[i];
    end
endmodule // bsj_bit_alu

/* File: rtl/bsj_exec.sv */
// Decode and execute sequencer for bit set, bit clear and absolute jump.
`timescale 1ns/1ns
`include "bsj_defs.svh"
// What this block does
// - Prefix CB, top bits 11 sets register bit.
// - Bit field binary; register codes B..L, A=111.
// - Register code 110 targets byte at main pointer.
// - DD form addresses first index plus signed displacement.
// - FD form addresses second index plus displacement.
// - Indexed forms take 23 states: 4,4,3,5,4,3.
// - Clear forms match set forms, top bits 10.
// - Bit 0 is the least significant bit.
// - Jump opcode C3, low address byte first.
module bsj_exec (
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic              run,
    input  wire logic              load_en,
    input  wire logic [3:0]        load_sel,
    input  wire logic [15:0]       load_val,
    input  wire logic [7:0]        mem_rdata,
    output logic      [15:0]       mem_addr_q,
    output logic                   mem_rd_q,
    output logic                   mem_wr_q,
    output logic      [7:0]        mem_wdata_q,
    output logic      [7:0][7:0]   gpr_q,
    output logic      [15:0]       first_index_pair_q,
    output logic      [15:0]       second_index_pair_q,
    output logic      [15:0]       program_counter_q,
    output logic                   instr_done_q
);
    bsj_pkg::bsj_state_type state_q, state_d, nxt;
    bsj_pkg::bsj_ptr_type   ptr_q, ptr_d;
    logic [2:0]      tcnt_q, tcnt_d, mlen;
    logic [4:0]      icnt_q, icnt_d;
    logic [15:0]     program_counter_d, first_index_pair_d, second_index_pair_d;
    logic [15:0]     ea_q, ea_d, npc, iaddr, addr_d, base;
    logic [7:0][7:0] gpr_d;
    logic [7:0]      op_q, op_d, disp_q, disp_d, jlo_q, jlo_d, rbyte_q, rbyte_d, wdata_d;
    logic            rd_d, wr_d, done_d, ird, iwr, fin, last;

    bsj_alu_if alu_bus ();

    bsj_bit_alu u_alu (
        .alu (alu_bus)
    );

    // ------------------------------------------------------------------
    // Bit modify operand routing
    // ------------------------------------------------------------------
    // Register forms modify during the operation fetch, memory forms on read.
    assign alu_bus.operand = (state_q == bsj_pkg::bsj_st_cbop) ?
                             gpr_q[mem_rdata[`BSJ_F_REG]] : mem_rdata;
    assign alu_bus.bit_sel = (state_q == bsj_pkg::bsj_st_cbop) ?
                             mem_rdata[`BSJ_F_BIT] : op_q[`BSJ_F_BIT];
    assign alu_bus.set_bit = (state_q == bsj_pkg::bsj_st_cbop) ?
                             mem_rdata[`BSJ_F_SETBIT] : op_q[`BSJ_F_SETBIT];

    // Length of the current machine cycle in clock states.
    always_comb begin
        case (state_q)
            bsj_pkg::bsj_st_disp:  mlen = `BSJ_T_DISP;
            bsj_pkg::bsj_st_ixop:  mlen = `BSJ_T_IXOP;
            bsj_pkg::bsj_st_mrd:   mlen = `BSJ_T_MRD;
            bsj_pkg::bsj_st_mwr:   mlen = `BSJ_T_MWR;
            bsj_pkg::bsj_st_jlo:   mlen = `BSJ_T_JBYTE;
            bsj_pkg::bsj_st_jhi:   mlen = `BSJ_T_JBYTE;
            default:               mlen = `BSJ_T_FETCH;
        endcase
    end

    assign last = (tcnt_q == 3'(mlen - 3'h1));
    assign base = (ptr_q == bsj_pkg::bsj_ptr_first) ? first_index_pair_q : second_index_pair_q;

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    // Each machine cycle drives its address at its first state and samples
    // the memory byte at its last; the next cycle's address is set there.
    always_comb begin
        state_d = state_q;
        tcnt_d  = 3'(tcnt_q + 3'h1);
        program_counter_d   = program_counter_q;
        first_index_pair_d  = first_index_pair_q;
        second_index_pair_d = second_index_pair_q;
        gpr_d   = gpr_q;
        op_d    = op_q;
        disp_d  = disp_q;
        ptr_d   = ptr_q;
        ea_d    = ea_q;
        jlo_d   = jlo_q;
        rbyte_d = rbyte_q;
        addr_d  = mem_addr_q;
        rd_d    = mem_rd_q;
        wr_d    = mem_wr_q;
        wdata_d = mem_wdata_q;
        done_d  = 1'b0;
        nxt     = state_q;
        fin     = 1'b0;
        npc     = program_counter_q;
        iaddr   = mem_addr_q;
        ird     = 1'b0;
        iwr     = 1'b0;
        if (state_q == bsj_pkg::bsj_st_idle) begin
            tcnt_d = 3'h0;
            if (run) begin
                state_d = bsj_pkg::bsj_st_fetch;
                addr_d  = program_counter_q;
                rd_d    = 1'b1;
            end else if (load_en) begin
                case (load_sel)
                    `BSJ_LD_FIRST:  first_index_pair_d = load_val;
                    `BSJ_LD_SECOND: second_index_pair_d = load_val;
                    `BSJ_LD_COUNT:  program_counter_d = load_val;
                    default: begin
                        if (!load_sel[3]) begin
                            gpr_d[load_sel[2:0]] = load_val[7:0];
                        end
                    end
                endcase
            end
        end else if (last) begin
            case (state_q)
                bsj_pkg::bsj_st_fetch: begin
                    npc   = 16'(program_counter_q + 16'h0001);
                    iaddr = npc;
                    ird   = 1'b1;
                    if (mem_rdata == `BSJ_OP_CB) begin
                        nxt   = bsj_pkg::bsj_st_cbop;
                        ptr_d = bsj_pkg::bsj_ptr_main;
                    end else if (mem_rdata == `BSJ_OP_DD) begin
                        nxt   = bsj_pkg::bsj_st_pfx2;
                        ptr_d = bsj_pkg::bsj_ptr_first;
                    end else if (mem_rdata == `BSJ_OP_FD) begin
                        nxt   = bsj_pkg::bsj_st_pfx2;
                        ptr_d = bsj_pkg::bsj_ptr_second;
                    end else if (mem_rdata == `BSJ_OP_ABS) begin
                        nxt = bsj_pkg::bsj_st_jlo;
                    end else begin
                        fin = 1'b1;
                    end
                end
                bsj_pkg::bsj_st_pfx2: begin
                    npc   = 16'(program_counter_q + 16'h0001);
                    iaddr = npc;
                    ird   = 1'b1;
                    if (mem_rdata == `BSJ_OP_CB) begin
                        nxt = bsj_pkg::bsj_st_disp;
                    end else begin
                        fin = 1'b1;
                    end
                end
                bsj_pkg::bsj_st_cbop: begin
                    npc  = 16'(program_counter_q + 16'h0001);
                    op_d = mem_rdata;
                    if (mem_rdata[`BSJ_F_GRP] == `BSJ_GRP_SET ||
                        mem_rdata[`BSJ_F_GRP] == `BSJ_GRP_CLR) begin
                        if (mem_rdata[`BSJ_F_REG] == `BSJ_R_MEM) begin
                            ea_d  = {gpr_q[`BSJ_R_H], gpr_q[`BSJ_R_L]};
                            iaddr = ea_d;
                            ird   = 1'b1;
                            nxt   = bsj_pkg::bsj_st_mrd;
                        end else begin
                            gpr_d[mem_rdata[`BSJ_F_REG]] = alu_bus.result;
                            fin = 1'b1;
                        end
                    end else begin
                        fin = 1'b1;
                    end
                end
                bsj_pkg::bsj_st_disp: begin
                    npc    = 16'(program_counter_q + 16'h0001);
                    disp_d = mem_rdata;
                    iaddr  = npc;
                    ird    = 1'b1;
                    nxt    = bsj_pkg::bsj_st_ixop;
                end
                bsj_pkg::bsj_st_ixop: begin
                    npc  = 16'(program_counter_q + 16'h0001);
                    op_d = mem_rdata;
                    // Signed displacement is sign extended before the add.
                    ea_d = 16'(base + {{8{disp_q[7]}}, disp_q});
                    if (mem_rdata[`BSJ_F_GRP] == `BSJ_GRP_SET ||
                        mem_rdata[`BSJ_F_GRP] == `BSJ_GRP_CLR) begin
                        iaddr = ea_d;
                        ird   = 1'b1;
                        nxt   = bsj_pkg::bsj_st_mrd;
                    end else begin
                        fin = 1'b1;
                    end
                end
                bsj_pkg::bsj_st_mrd: begin
                    rbyte_d = mem_rdata;
                    wdata_d = alu_bus.result;
                    iaddr   = ea_q;
                    iwr     = 1'b1;
                    nxt     = bsj_pkg::bsj_st_mwr;
                end
                bsj_pkg::bsj_st_mwr: begin
                    fin = 1'b1;
                end
                bsj_pkg::bsj_st_jlo: begin
                    npc   = 16'(program_counter_q + 16'h0001);
                    jlo_d = mem_rdata;
                    iaddr = npc;
                    ird   = 1'b1;
                    nxt   = bsj_pkg::bsj_st_jhi;
                end
                bsj_pkg::bsj_st_jhi: begin
                    npc = {mem_rdata, jlo_q};
                    fin = 1'b1;
                end
                default: begin
                    fin = 1'b1;
                end
            endcase
            // Finishing an instruction starts the next fetch at the new counter while run is high, else goes idle.
            if (fin) begin
                nxt    = run ? bsj_pkg::bsj_st_fetch : bsj_pkg::bsj_st_idle;
                iaddr  = npc;
                ird    = run;
                iwr    = 1'b0;
                done_d = 1'b1;
            end
            state_d = nxt;
            tcnt_d  = 3'h0;
            program_counter_d = npc;
            addr_d  = iaddr;
            rd_d    = ird;
            wr_d    = iwr;
        end
        icnt_d = (state_q == bsj_pkg::bsj_st_idle || fin) ? 5'h00 : 5'(icnt_q + 5'h01);
    end

    // Registers the sequencer state and all outputs.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q             <= bsj_pkg::bsj_st_idle;
            ptr_q               <= bsj_pkg::bsj_ptr_main;
            tcnt_q              <= 3'h0;
            icnt_q              <= 5'h00;
            program_counter_q   <= `BSJ_RST_COUNT;
            first_index_pair_q  <= 16'h0000;
            second_index_pair_q <= 16'h0000;
            gpr_q               <= 64'h0;
            op_q                <= 8'h00;
            disp_q              <= 8'h00;
            ea_q                <= 16'h0000;
            jlo_q               <= 8'h00;
            rbyte_q             <= 8'h00;
            mem_addr_q          <= 16'h0000;
            mem_rd_q            <= 1'b0;
            mem_wr_q            <= 1'b0;
            mem_wdata_q         <= 8'h00;
            instr_done_q        <= 1'b0;
        end else begin
            state_q             <= state_d;
            ptr_q               <= ptr_d;
            tcnt_q              <= tcnt_d;
            icnt_q              <= icnt_d;
            program_counter_q   <= program_counter_d;
            first_index_pair_q  <= first_index_pair_d;
            second_index_pair_q <= second_index_pair_d;
            gpr_q               <= gpr_d;
            op_q                <= op_d;
            disp_q              <= disp_d;
            ea_q                <= ea_d;
            jlo_q               <= jlo_d;
            rbyte_q             <= rbyte_d;
            mem_addr_q          <= addr_d;
            mem_rd_q            <= rd_d;
            mem_wr_q            <= wr_d;
            mem_wdata_q         <= wdata_d;
            instr_done_q        <= done_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Register form leaves the chosen bit at the value its group asks for.
    reg_bit_a: assert property (
        state_q == bsj_pkg::bsj_st_cbop && last && mem_rdata[7] &&
        mem_rdata[`BSJ_F_REG] != `BSJ_R_MEM
        |=> gpr_q[op_q[`BSJ_F_REG]][op_q[`BSJ_F_BIT]] == op_q[`BSJ_F_SETBIT])
        else $error("register bit not updated");
    mainptr_addr_a: assert property (
        state_q == bsj_pkg::bsj_st_mrd && tcnt_q == 3'h0 && ptr_q == bsj_pkg::bsj_ptr_main
        |-> mem_addr_q == {gpr_q[`BSJ_R_H], gpr_q[`BSJ_R_L]} && mem_rd_q)
        else $error("main pointer address wrong");
    first_addr_a: assert property (
        state_q == bsj_pkg::bsj_st_mrd && tcnt_q == 3'h0 && ptr_q == bsj_pkg::bsj_ptr_first
        |-> mem_addr_q == 16'(first_index_pair_q + {{8{disp_q[7]}}, disp_q}))
        else $error("first index address wrong");
    second_addr_a: assert property (
        state_q == bsj_pkg::bsj_st_mrd && tcnt_q == 3'h0 && ptr_q == bsj_pkg::bsj_ptr_second
        |-> mem_addr_q == 16'(second_index_pair_q + {{8{disp_q[7]}}, disp_q}))
        else $error("second index address wrong");
    indexed_time_a: assert property (
        fin && state_q == bsj_pkg::bsj_st_mwr && ptr_q != bsj_pkg::bsj_ptr_main
        |-> icnt_q == 5'(`BSJ_T_INDEXED - 5'h01))
        else $error("indexed instruction length wrong");
    clr_mem_a: assert property (
        state_q == bsj_pkg::bsj_st_mwr && tcnt_q == 3'h0 && op_q[`BSJ_F_GRP] == `BSJ_GRP_CLR
        |-> mem_wr_q && !mem_wdata_q[op_q[`BSJ_F_BIT]] && mem_addr_q == ea_q)
        else $error("clear did not write zero");
    one_bit_a: assert property (
        state_q == bsj_pkg::bsj_st_mwr && tcnt_q == 3'h0
        |-> (mem_wdata_q & ~(8'(8'h01 << op_q[`BSJ_F_BIT]))) ==
            (rbyte_q & ~(8'(8'h01 << op_q[`BSJ_F_BIT]))))
        else $error("other bits changed");
    jump_tgt_a: assert property (
        state_q == bsj_pkg::bsj_st_jhi && last && run
        |=> mem_addr_q == program_counter_q && mem_rd_q &&
            program_counter_q[7:0] == jlo_q && state_q == bsj_pkg::bsj_st_fetch)
        else $error("jump target not fetched");
    jump_time_a: assert property (
        fin && state_q == bsj_pkg::bsj_st_jhi |-> icnt_q == 5'(`BSJ_T_ABS - 5'h01))
        else $error("jump length wrong");

    cov_indexed_c: cover property (fin && state_q == bsj_pkg::bsj_st_mwr &&
                                   ptr_q == bsj_pkg::bsj_ptr_second);
    cov_main_clr_c: cover property (state_q == bsj_pkg::bsj_st_mwr &&
                                   ptr_q == bsj_pkg::bsj_ptr_main && !op_q[6]);
    cov_jump_c:    cover property (fin && state_q == bsj_pkg::bsj_st_jhi);
endmodule // bsj_exec

/* File: testbench/bsj_mem_model.sv */
// Behavioural instruction and data memory facing the bit set, clear and jump executor.
`timescale 1ns/1ns
module bsj_mem_model (
    clock,
    slow,
    mem_addr_q,
    mem_rd_q,
    mem_wr_q,
    mem_wdata_q,
    mem_rdata
);
    input  wire logic        clock;
    input  wire logic        slow;
    input  wire logic [15:0] mem_addr_q;
    input  wire logic        mem_rd_q;
    input  wire logic        mem_wr_q;
    input  wire logic [7:0]  mem_wdata_q;
    output logic      [7:0]  mem_rdata;

    logic [7:0]  bytes [0:65535];
    logic [7:0]  last_q      = 8'h00;
    logic [2:0]  age_q       = 3'h0;
    logic [15:0] addr_prev_q = 16'h0000;
    logic        rd_prev_q   = 1'b0;
    logic        fresh;
    logic [2:0]  age_now;

    // --------------------------------------------------------------
    // Read path
    // --------------------------------------------------------------
    // A slow memory shows data only from the third clock of a cycle on; outside reads the
    // bus shows the inverse of the last value so a stale byte is never mistaken for data.
    always_comb begin
        fresh = (mem_addr_q != addr_prev_q) || (mem_rd_q && !rd_prev_q);
        age_now = fresh ? 3'h0 : age_q;
        if (mem_rd_q && (!slow || age_now >= 3'h2)) begin
            mem_rdata = bytes[mem_addr_q];
        end else begin
            mem_rdata = ~last_q;
        end
    end

    // --------------------------------------------------------------
    // Write path and cycle age
    // --------------------------------------------------------------
    // Writes land on every strobed edge; repeating the same byte is harmless.
    always @(posedge clock) begin
        if (mem_wr_q) begin
            bytes[mem_addr_q] <= mem_wdata_q;
        end
        age_q <= (age_now == 3'h7) ? age_now : age_now + 3'h1;
        addr_prev_q <= mem_addr_q;
        rd_prev_q <= mem_rd_q;
        last_q <= mem_rdata;
    end
endmodule // bsj_mem_model

/* File: testbench/bit_set_clear_and_jump_exec_bench.sv */
// Self-checking testbench of the bit set, clear and jump executor.
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module bit_set_clear_and_jump_exec_bench;
    logic             clock    = 1'b0;
    logic             arst_n   = 1'b0;
    logic             run      = 1'b0;
    logic             load_en  = 1'b0;
    logic [3:0]       load_sel = 4'h0;
    logic [15:0]      load_val = 16'h0000;
    logic             slow     = 1'b0;
    logic [7:0]       mem_rdata;
    logic [15:0]      mem_addr_q;
    logic             mem_rd_q;
    logic             mem_wr_q;
    logic [7:0]       mem_wdata_q;
    logic [7:0][7:0]  gpr;
    logic [15:0]      counter;
    logic [15:0]      first_pair;
    logic [15:0]      second_pair;
    logic             done;
    int               num_errors = 0;
    int               n_compared = 0;
    int               cyc = 0;
    int               last_done = 0;
    int               wr_cyc = 0;
    logic             wr_prev = 1'b0;
    int               dq[$];
    int               wq[$];
    logic [15:0]      wp;

    bsj_exec i_bsj_exec (.clock(clock), .arst_n(arst_n), .run(run), .load_en(load_en),
        .load_sel(load_sel), .load_val(load_val), .mem_rdata(mem_rdata),
        .mem_addr_q(mem_addr_q), .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q),
        .mem_wdata_q(mem_wdata_q), .gpr_q(gpr), .first_index_pair_q(first_pair),
        .second_index_pair_q(second_pair), .program_counter_q(counter),
        .instr_done_q(done));
    bsj_mem_model i_bsj_mem_model (.clock(clock), .slow(slow), .mem_addr_q(mem_addr_q),
        .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q), .mem_wdata_q(mem_wdata_q),
        .mem_rdata(mem_rdata));

    // --------------------------------------------------------------
    // Clock, watchdog and timing monitor
    // --------------------------------------------------------------
    // The clock toggles every 4 ns, a period of 8 ns.
    initial begin
        forever #4 clock = ~clock;
    end

    // Records the gap between completions and from write start to completion.
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (mem_wr_q === 1'b1 && !wr_prev) wr_cyc = cyc;
        wr_prev = (mem_wr_q === 1'b1);
        if (done === 1'b1) begin
            dq.push_back(cyc - last_done);
            last_done = cyc;
            if (wr_cyc != 0) wq.push_back(cyc - wr_cyc);
            wr_cyc = 0;
        end
        if (cyc == 30000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic tally_and_finish();
        $display("mismatches %0d, compares %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic load_reg(input logic [3:0] sel, input logic [15:0] val);
        @(posedge clock);
        load_en <= 1'b1;
        load_sel <= sel;
        load_val <= val;
    endtask

    task automatic emit(input logic [7:0] b);
        i_bsj_mem_model.bytes[wp] = b;
        wp = wp + 16'h0001;
    endtask

    // Runs n instructions plus the trailing jump, then lets the sequencer settle in idle.
    task automatic exec(input int n);
        int k;
        @(posedge clock);
        load_en <= 1'b0;
        run <= 1'b1;
        dq.delete();
        wq.delete();
        for (k = 0; k < 4000 && dq.size() < n; k++) @(posedge clock);
        run <= 1'b0;
        for (k = 0; k < 200 && dq.size() < n + 1; k++) @(posedge clock);
        repeat (3) @(posedge clock);
        `CHK(dq.size(), n + 1)
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    // Every bit number and register code, setting from zero or clearing from all ones.
    task automatic reg_ops(input logic clr);
        logic [2:0] rs [0:7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h7};
        logic [7:0] ev [0:7];
        int i;
        for (i = 0; i < 8; i++) begin
            load_reg(i[3:0], clr ? 16'h00ff : 16'h0000);
            ev[i] = clr ? 8'hff : 8'h00;
        end
        load_reg(4'ha, 16'h0100);
        wp = 16'h0100;
        for (i = 0; i < 8; i++) begin
            emit(8'hcb);
            emit({clr ? 2'h2 : 2'h3, i[2:0], rs[i]});
            ev[rs[i]][i] = !clr;
        end
        emit(8'hc3);
        emit(8'h10);
        emit(8'h01);
        exec(8);
        for (i = 1; i < 8; i++) `CHK(dq[i], 8)
        for (i = 0; i < 8; i++) `CHK(gpr[i], ev[i])
        `CHK(counter, 16'h0110)
    endtask

    // Set then clear in the byte at the main pointer; neighbours stay intact.
    task automatic main_ptr_ops();
        load_reg(4'h4, 16'h0030);
        load_reg(4'h5, 16'h0000);
        load_reg(4'ha, 16'h0200);
        i_bsj_mem_model.bytes[16'h2fff] = 8'h00;
        i_bsj_mem_model.bytes[16'h3000] = 8'h5a;
        i_bsj_mem_model.bytes[16'h3001] = 8'hff;
        wp = 16'h0200;
        emit(8'hcb);
        emit(8'hc6);
        emit(8'hcb);
        emit(8'h9e);
        emit(8'hc3);
        emit(8'h04);
        emit(8'h02);
        exec(2);
        `CHK(dq[1], 15)
        `CHK(i_bsj_mem_model.bytes[16'h3000], 8'h53)
        `CHK(i_bsj_mem_model.bytes[16'h2fff], 8'h00)
        `CHK(i_bsj_mem_model.bytes[16'h3001], 8'hff)
    endtask

    // Indexed forms with extreme displacements against a slow memory.
    task automatic idx_ops();
        logic [7:0] prog [0:18] = '{8'hdd, 8'hcb, 8'h04, 8'hc6, 8'hdd, 8'hcb, 8'h7f, 8'hfe,
            8'hfd, 8'hcb, 8'h80, 8'hbe, 8'hfd, 8'hcb, 8'h01, 8'h96, 8'hc3, 8'h10, 8'h03};
        int i;
        slow <= 1'b1;
        load_reg(4'h8, 16'h2000);
        load_reg(4'h9, 16'h4000);
        load_reg(4'ha, 16'h0300);
        i_bsj_mem_model.bytes[16'h2004] = 8'h00;
        i_bsj_mem_model.bytes[16'h207f] = 8'h0f;
        i_bsj_mem_model.bytes[16'h3f80] = 8'hff;
        i_bsj_mem_model.bytes[16'h4001] = 8'hff;
        wp = 16'h0300;
        for (i = 0; i < 19; i++) emit(prog[i]);
        exec(4);
        for (i = 1; i < 4; i++) `CHK(dq[i], 23)
        `CHK(wq[0], 3)
        `CHK(i_bsj_mem_model.bytes[16'h2004], 8'h01)
        `CHK(i_bsj_mem_model.bytes[16'h207f], 8'h8f)
        `CHK(i_bsj_mem_model.bytes[16'h3f80], 8'h7f)
        `CHK(i_bsj_mem_model.bytes[16'h4001], 8'hfb)
        `CHK(first_pair, 16'h2000)
        `CHK(second_pair, 16'h4000)
        slow <= 1'b0;
    endtask

    // A bit-test op byte that must change nothing, a jump, then a jump to itself.
    task automatic jump_ops();
        load_reg(4'ha, 16'h0500);
        wp = 16'h0500;
        emit(8'hcb);
        emit(8'h7f);
        emit(8'hc3);
        emit(8'h34);
        emit(8'h12);
        wp = 16'h1234;
        emit(8'hc3);
        emit(8'h34);
        emit(8'h12);
        exec(2);
        `CHK(dq[1], 10)
        `CHK(dq[2], 10)
        `CHK(counter, 16'h1234)
        `CHK(gpr[7], 8'h3f)
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    // Holds reset for five clocks, checks idle outputs, then runs the scenarios.
    initial begin
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        `CHK(counter, 16'h0000)
        `CHK(mem_rd_q, 1'b0)
        reg_ops(1'b0);
        reg_ops(1'b1);
        main_ptr_ops();
        idx_ops();
        jump_ops();
        tally_and_finish();
    end
endmodule // bit_set_clear_and_jump_exec_bench
